// ===== lndid_pkg.sv
// package: constants and carriers for the lin identifier assignment block
`default_nettype none
package lndid_pkg;
    // frame identifiers and markers
    localparam logic [5:0] ID_CMD = 6'h3c;
    localparam logic [5:0] ID_EXT = 6'h3f;
    localparam logic [5:0] ID_READ = 6'h3d;
    localparam logic [7:0] APP_MARK = 8'h80;
    localparam logic [7:0] ASSIGN_CODE = 8'h91;
    localparam logic [3:0] LEN_FULL = 4'h8;
    localparam logic [3:0] LEN_MID = 4'h4;
    localparam logic [3:0] LEN_SHORT = 4'h2;
    localparam logic [5:0] MASK_ALL = 6'h3f;
    localparam logic [5:0] MASK_FREE = 6'h38;
    // command slot pointers
    localparam int NPTR = 10;
    localparam logic [3:0] PTR_GP2 = 4'h0;
    localparam logic [3:0] PTR_GP4 = 4'h1;
    localparam logic [3:0] PTR_RD_LOC = 4'h2;
    localparam logic [3:0] PTR_RD_SHORT = 4'h3;
    localparam logic [3:0] PTR_MOVE = 4'h4;
    localparam logic [3:0] PTR_CMP1 = 4'h5;
    localparam logic [3:0] PTR_CMP2 = 4'h6;
    localparam logic [3:0] PTR_CMP4 = 4'h7;
    localparam logic [3:0] PTR_PREP = 4'h8;
    localparam logic [3:0] PTR_MOVE_PAR = 4'h9;
    // application command codes
    localparam logic [6:0] C_RD_LOC = 7'h00;
    localparam logic [6:0] C_RD_ALL = 7'h01;
    localparam logic [6:0] C_RD_FUSE = 7'h02;
    localparam logic [6:0] C_RD_SHORT = 7'h03;
    localparam logic [6:0] C_SAFE = 7'h04;
    localparam logic [6:0] C_HALT = 7'h05;
    localparam logic [6:0] C_ZERO_POS = 7'h06;
    localparam logic [6:0] C_REF = 7'h08;
    localparam logic [6:0] C_MOTION = 7'h09;
    localparam logic [6:0] C_MOVE = 7'h0b;
    localparam logic [6:0] C_CMP1 = 7'h0c;
    localparam logic [6:0] C_CMP2 = 7'h0d;
    localparam logic [6:0] C_CMP4 = 7'h0e;
    localparam logic [6:0] C_DECEL = 7'h0f;
    localparam logic [6:0] C_FUSE_WR = 7'h10;
    localparam logic [6:0] C_STALL = 7'h16;
    localparam logic [6:0] C_MOVE_PAR = 7'h2f;
    localparam logic [6:0] C_NONE = 7'h7f;
    // link loss
    localparam int LOSS_FRAMES = 25000;
    localparam logic [10:0] SAFE_NONE = 11'h400;
    // register map, byte addresses
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_STAT = 12'h004;
    localparam logic [11:0] A_IRQ = 12'h008;
    localparam logic [11:0] A_MASK = 12'h00c;
    localparam logic [11:0] A_SAFE = 12'h010;
    localparam logic [11:0] A_TAB = 12'h040;
    localparam int CF_SLEEP = 8;
    localparam int CF_FS = 9;
    localparam int IB_ASSIGN = 0;
    localparam int IB_CMD = 1;
    localparam int IB_LOSS = 2;
    localparam int IB_CHK = 3;
    localparam int NIRQ = 4;
    // received frame from the lin frame layer
    typedef struct packed {
        logic [7:0] id;
        logic [3:0] len;
        logic chk_ok;
        logic [7:0][7:0] data;
    } lndid_frame_s;
    // command handed to the application
    typedef struct packed {
        logic [6:0] code;
        logic [3:0] ptr;
        logic [7:0][7:0] data;
    } lndid_cmd_s;
endpackage
`default_nettype wire

// ===== lndid_core.sv
// module: lin dynamic identifier table, command mapping and link loss
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module lndid_core #(
    parameter int LOSS_FRAMES = lndid_pkg::LOSS_FRAMES
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic ce,
    input wire lndid_pkg::lndid_frame_s frm,
    input wire logic frm_valid,
    input wire logic frame_tick,
    input wire logic motor_quiet,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic cmd_valid,
    output lndid_pkg::lndid_cmd_s cmd,
    output logic link_lost,
    output logic sleep_req,
    output logic ref_move_start,
    output logic safe_move_start,
    output logic irq
);
    typedef enum logic [1:0] {
        LNDID_IDLE = 2'b01,
        LNDID_ACCESS = 2'b10
    } lndid_bus_e;

    ////////////////////////////////////////////////////////////////////////
    // functions

    function automatic logic cmd_known(input logic [6:0] c);
        case (c)
            lndid_pkg::C_RD_LOC, lndid_pkg::C_RD_ALL, lndid_pkg::C_RD_FUSE,
            lndid_pkg::C_RD_SHORT, lndid_pkg::C_SAFE, lndid_pkg::C_HALT,
            lndid_pkg::C_ZERO_POS, lndid_pkg::C_REF, lndid_pkg::C_MOTION,
            lndid_pkg::C_MOVE, lndid_pkg::C_CMP1, lndid_pkg::C_CMP2,
            lndid_pkg::C_CMP4, lndid_pkg::C_DECEL, lndid_pkg::C_FUSE_WR,
            lndid_pkg::C_STALL, lndid_pkg::C_MOVE_PAR: cmd_known = 1'b1;
            default: cmd_known = 1'b0;
        endcase
    endfunction

    // direct pointer to command code
    function automatic logic [6:0] ptr_cmd(input logic [3:0] p);
        case (p)
            lndid_pkg::PTR_RD_LOC: ptr_cmd = lndid_pkg::C_RD_LOC;
            lndid_pkg::PTR_RD_SHORT: ptr_cmd = lndid_pkg::C_RD_SHORT;
            lndid_pkg::PTR_MOVE: ptr_cmd = lndid_pkg::C_MOVE;
            lndid_pkg::PTR_CMP1: ptr_cmd = lndid_pkg::C_CMP1;
            lndid_pkg::PTR_CMP2: ptr_cmd = lndid_pkg::C_CMP2;
            lndid_pkg::PTR_CMP4: ptr_cmd = lndid_pkg::C_CMP4;
            lndid_pkg::PTR_MOVE_PAR: ptr_cmd = lndid_pkg::C_MOVE_PAR;
            default: ptr_cmd = lndid_pkg::C_NONE;
        endcase
    endfunction

    // identifier bits compared against the table; the rest carry the address
    function automatic logic [5:0] ptr_mask(input logic [3:0] p);
        case (p)
            lndid_pkg::PTR_RD_LOC, lndid_pkg::PTR_RD_SHORT, lndid_pkg::PTR_MOVE,
            lndid_pkg::PTR_MOVE_PAR: ptr_mask = lndid_pkg::MASK_FREE;
            default: ptr_mask = lndid_pkg::MASK_ALL;
        endcase
    endfunction

    function automatic logic [3:0] gp_len(input logic [5:0] id);
        case (id[5:4])
            2'b11: gp_len = lndid_pkg::LEN_FULL;
            2'b10: gp_len = lndid_pkg::LEN_MID;
            default: gp_len = lndid_pkg::LEN_SHORT;
        endcase
    endfunction

    function automatic logic rsv_id(input logic [5:0] id);
        rsv_id = (id == lndid_pkg::ID_CMD) || (id == lndid_pkg::ID_EXT);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    logic [6:0] phys;
    logic sleep_en;
    logic failsafe;
    logic [10:0] safe_pos;
    logic [lndid_pkg::NIRQ-1:0] irq_stat;
    logic [lndid_pkg::NIRQ-1:0] irq_mask;
    logic [lndid_pkg::NPTR-1:0][5:0] tab_id;
    logic [lndid_pkg::NPTR-1:0] tab_v;
    logic prep_armed;
    logic [6:0] prep_cmd;
    logic comm_seen;
    logic referenced;
    logic [14:0] silence;
    logic loss_d;
    lndid_bus_e bus_st;
    logic [lndid_pkg::NIRQ-1:0] ev;

    ////////////////////////////////////////////////////////////////////////
    // frame classification

    logic [5:0] id6;
    logic hit;
    logic [3:0] hit_ptr;
    logic [39:0] pairs;
    logic is_cmd;
    logic is_assign;
    logic is_prep;
    logic [6:0] prep_code;
    logic is_gp;
    logic is_direct;
    logic take;

    assign id6 = frm.id[5:0];
    assign pairs = frm.data[7:3];
    assign take = ce && frm_valid && frm.chk_ok;

    // first table entry whose identifier matches; free bits must carry phys
    always_comb begin
        logic [5:0] m;
        m = '0;
        hit = 1'b0;
        hit_ptr = '0;
        for (int i = 0; i < lndid_pkg::NPTR; i++) begin
            m = ptr_mask(4'(i));
            if (!hit && tab_v[i] && (((id6 ^ tab_id[i]) & m)
                    | ((id6 ^ phys[5:0]) & ~m)) == 6'h00) begin
                hit = 1'b1;
                hit_ptr = 4'(i);
            end
        end
    end

    assign is_cmd = (id6 == lndid_pkg::ID_CMD) && (frm.len == lndid_pkg::LEN_FULL)
        && (frm.data[0] == lndid_pkg::APP_MARK);
    assign is_assign = is_cmd && (frm.data[1] == lndid_pkg::ASSIGN_CODE)
        && (!frm.data[2][7] || frm.data[2][6:0] == phys);

    // preparing frame, either on the command identifier or on pointer 8
    always_comb begin
        is_prep = 1'b0;
        prep_code = frm.data[1][6:0];
        if (is_cmd && !is_assign && frm.data[1][7] && frm.data[2][7]
                && frm.data[2][6:0] == phys) begin
            is_prep = 1'b1;
        end else if (hit && hit_ptr == lndid_pkg::PTR_PREP && frm.data[0][7]
                && frm.data[1][7] && frm.data[1][6:0] == phys) begin
            is_prep = 1'b1;
            prep_code = frm.data[0][6:0];
        end
    end

    assign is_gp = hit && (hit_ptr == lndid_pkg::PTR_GP2 || hit_ptr == lndid_pkg::PTR_GP4)
        && frm.len == gp_len(id6) && cmd_known(frm.data[0][6:0])
        && (!frm.data[1][7] || frm.data[1][6:0] == phys);
    assign is_direct = hit && ptr_cmd(hit_ptr) != lndid_pkg::C_NONE;

    ////////////////////////////////////////////////////////////////////////
    // identifier table; a failed checksum leaves it untouched

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            tab_id <= '0;
            tab_v <= '0;
        end else if (take && is_assign) begin
            for (int k = 0; k < 4; k++) begin
                if (pairs[10*k +: 4] < 4'(lndid_pkg::NPTR)
                        && !rsv_id(pairs[10*k+4 +: 6])) begin
                    tab_id[pairs[10*k +: 4]] <= pairs[10*k+4 +: 6];
                    tab_v[pairs[10*k +: 4]] <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // command dispatch and preparing-frame tracking

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            cmd_valid <= 1'b0;
            cmd <= '0;
            prep_armed <= 1'b0;
            prep_cmd <= '0;
            referenced <= 1'b0;
        end else if (ce) begin
            cmd_valid <= 1'b0;
            if (frm_valid) begin
                // any frame ends the preparing window
                prep_armed <= take && is_prep;
                prep_cmd <= prep_code;
            end
            if (take) begin
                if (id6 == lndid_pkg::ID_READ && prep_armed) begin
                    cmd_valid <= 1'b1;
                    cmd <= '{code: prep_cmd, ptr: lndid_pkg::PTR_PREP, data: frm.data};
                end else if (is_gp) begin
                    cmd_valid <= 1'b1;
                    cmd <= '{code: frm.data[0][6:0], ptr: hit_ptr, data: frm.data};
                    if (frm.data[0][6:0] == lndid_pkg::C_REF) begin
                        referenced <= 1'b1;
                    end
                end else if (is_direct) begin
                    cmd_valid <= 1'b1;
                    cmd <= '{code: ptr_cmd(hit_ptr), ptr: hit_ptr, data: frm.data};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link loss detection and reaction

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            silence <= '0;
            link_lost <= 1'b0;
            comm_seen <= 1'b0;
        end else if (ce) begin
            if (frm_valid) begin
                silence <= '0;
                link_lost <= 1'b0;
                comm_seen <= 1'b1;
            end else if (frame_tick && !link_lost) begin
                if (silence == 15'(LOSS_FRAMES - 1)) begin
                    link_lost <= 1'b1;
                end else begin
                    silence <= silence + 15'h0001;
                end
            end
        end
    end

    // reaction pulses on the rising edge of the loss flag; sleep request is a level held while the loss flag is set and sleep is enabled or the motor is quiet
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            loss_d <= 1'b0;
            ref_move_start <= 1'b0;
            safe_move_start <= 1'b0;
            sleep_req <= 1'b0;
        end else if (ce) begin
            loss_d <= link_lost;
            // position is unknown if never referenced or lost at power on
            ref_move_start <= link_lost && !loss_d && failsafe
                && (!referenced || !comm_seen);
            safe_move_start <= link_lost && !loss_d && failsafe
                && safe_pos != lndid_pkg::SAFE_NONE;
            sleep_req <= link_lost && (sleep_en || motor_quiet);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // apb slave: one wait state, pready and data from flops

    logic acc;
    logic wr;
    logic [31:0] rd_val;
    logic rd_err;

    assign acc = psel && penable && bus_st == LNDID_ACCESS;
    assign wr = acc && pwrite;

    always_comb begin
        rd_val = '0;
        rd_err = 1'b0;
        case (paddr)
            lndid_pkg::A_CTRL: rd_val = {22'h0, failsafe, sleep_en, 1'b0, phys};
            lndid_pkg::A_STAT: rd_val = {28'h0, prep_armed, referenced, comm_seen, link_lost};
            lndid_pkg::A_IRQ: rd_val = {28'h0, irq_stat};
            lndid_pkg::A_MASK: rd_val = {28'h0, irq_mask};
            lndid_pkg::A_SAFE: rd_val = {21'h0, safe_pos};
            default: begin
                if (paddr[11:6] == lndid_pkg::A_TAB[11:6] && paddr[1:0] == 2'b00
                        && paddr[5:2] < 4'(lndid_pkg::NPTR)) begin
                    rd_val = {25'h0, tab_v[paddr[5:2]], tab_id[paddr[5:2]]};
                end else begin
                    rd_err = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bus_st <= LNDID_IDLE;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            case (bus_st)
                LNDID_IDLE: begin
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                    if (psel && penable) begin
                        bus_st <= LNDID_ACCESS;
                        pready <= 1'b1;
                        pslverr <= rd_err;
                        prdata <= pwrite ? 32'h0 : rd_val;
                    end
                end
                LNDID_ACCESS: begin
                    bus_st <= LNDID_IDLE;
                    pready <= 1'b0;
                    pslverr <= 1'b0;
                end
                default: bus_st <= LNDID_IDLE;
            endcase
        end
    end

    // software settings; sleep on loss is blocked until enabled or the motor is quiet
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            phys <= '0;
            sleep_en <= 1'b0;
            failsafe <= 1'b0;
            safe_pos <= lndid_pkg::SAFE_NONE;
            irq_mask <= '0;
        end else if (ce && wr) begin
            case (paddr)
                lndid_pkg::A_CTRL: begin
                    phys <= pwdata[6:0];
                    sleep_en <= pwdata[lndid_pkg::CF_SLEEP];
                    failsafe <= pwdata[lndid_pkg::CF_FS];
                end
                lndid_pkg::A_MASK: irq_mask <= pwdata[lndid_pkg::NIRQ-1:0];
                lndid_pkg::A_SAFE: safe_pos <= pwdata[10:0];
                default: safe_pos <= safe_pos;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // interrupts: sticky events, write one to clear, set wins over clear

    always_comb begin
        ev = '0;
        ev[lndid_pkg::IB_ASSIGN] = take && is_assign;
        ev[lndid_pkg::IB_CMD] = cmd_valid;
        ev[lndid_pkg::IB_LOSS] = link_lost && !loss_d;
        ev[lndid_pkg::IB_CHK] = ce && frm_valid && !frm.chk_ok;
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            irq_stat <= '0;
            irq <= 1'b0;
        end else if (ce) begin
            irq_stat <= (irq_stat & ~((wr && paddr == lndid_pkg::A_IRQ)
                ? pwdata[lndid_pkg::NIRQ-1:0] : 4'h0)) | ev;
            irq <= |(irq_stat & irq_mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    logic any_rsv;
    always_comb begin
        any_rsv = 1'b0;
        for (int i = 0; i < lndid_pkg::NPTR; i++) begin
            any_rsv = any_rsv || (tab_v[i] && rsv_id(tab_id[i]));
        end
    end

    sequence s_assign_frame;
        take && is_assign && pairs[3:0] < 4'(lndid_pkg::NPTR) && !rsv_id(pairs[9:4])
            && pairs[3:0] != pairs[13:10] && pairs[3:0] != pairs[23:20]
            && pairs[3:0] != pairs[33:30];
    endsequence

    property p_no_reserved;
        !any_rsv;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved id stored");

    property p_bad_chk_keeps;
        ce && frm_valid && !frm.chk_ok |=> $stable(tab_id) && $stable(tab_v);
    endproperty
    a_bad_chk_keeps: assert property (p_bad_chk_keeps) else $error("table changed");

    property p_pair_stored;
        s_assign_frame |=> tab_v[$past(pairs[3:0])]
            && tab_id[$past(pairs[3:0])] == $past(pairs[9:4]);
    endproperty
    a_pair_stored: assert property (p_pair_stored) else $error("pair not stored");

    property p_foreign_ignored;
        ce && frm_valid && is_cmd && frm.data[1] == lndid_pkg::ASSIGN_CODE
            && frm.data[2][7] && frm.data[2][6:0] != phys |=> $stable(tab_v);
    endproperty
    a_foreign_ignored: assert property (p_foreign_ignored) else $error("foreign store");

    property p_indirect_needs_prep;
        ce && frm_valid && id6 == lndid_pkg::ID_READ && !prep_armed |=> !cmd_valid;
    endproperty
    a_indirect_needs_prep: assert property (p_indirect_needs_prep) else $error("bad read");

    property p_loss_sets;
        ce && frame_tick && !frm_valid && silence == 15'(LOSS_FRAMES - 1) |=> link_lost;
    endproperty
    a_loss_sets: assert property (p_loss_sets) else $error("loss not flagged");

    property p_sleep_blocked;
        ce && !sleep_en && !motor_quiet |=> !sleep_req;
    endproperty
    a_sleep_blocked: assert property (p_sleep_blocked) else $error("sleep not blocked");

    property p_safe_move_cause;
        safe_move_start |-> $past(link_lost) && $past(failsafe)
            && $past(safe_pos) != lndid_pkg::SAFE_NONE;
    endproperty
    a_safe_move_cause: assert property (p_safe_move_cause) else $error("bad safe move");
endmodule
`default_nettype wire

// ===== lndid_master.sv
// lin master model: hands decoded frames and frame-period ticks to the block
`timescale 1ns/100ps
`default_nettype none
module lndid_master (
    input wire logic clk_sys,
    output lndid_pkg::lndid_frame_s frm,
    output logic frm_valid,
    output logic frame_tick
);
    ////////////////////////////////////////////////////////////////////////////////
    // idle bus at time zero
    initial begin
        frm = '0;
        frm_valid = 1'b0;
        frame_tick = 1'b0;
    end
    // one frame; parity bits set high so that a full-byte match would fail
    task automatic send(input logic [5:0] id, input logic [3:0] len, input logic ok,
            input logic [63:0] d);
        @(posedge clk_sys);
        frm.id <= {2'b11, id};
        frm.len <= len;
        frm.chk_ok <= ok;
        frm.data <= d;
        frm_valid <= 1'b1;
        @(posedge clk_sys);
        frm_valid <= 1'b0;
        frm.data <= ~d; // stale data never looks valid
    endtask
    // assignment frame: marker, code with top bit, address, four packed pairs
    task automatic assign4(input logic [7:0] adr, input logic [39:0] pairs, input logic ok);
        send(6'h3c, 4'h8, ok, {pairs, adr, 8'h91, 8'h80});
    endtask
    // frame periods with no traffic at all
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            frame_tick <= 1'b1;
            @(posedge clk_sys);
            frame_tick <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ===== lndid_core_test.sv
// testbench for the lin identifier table, command mapping and link loss
`timescale 1ns/100ps
`default_nettype none
module lndid_core_test;
    logic clk_sys, sys_rst, motor_quiet, psel, penable, pwrite, pready, pslverr, err;
    logic cmd_valid, link_lost, sleep_req, ref_move_start, safe_move_start, irq;
    logic frm_valid, frame_tick;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    lndid_pkg::lndid_frame_s frm;
    lndid_pkg::lndid_cmd_s cmd;
    int error_cnt = 0;
    int checks_done = 0;
    int n_cmd = 0;
    int n_safe = 0;
    int n_ref = 0;
    logic [6:0] last_code;
    logic [3:0] last_ptr;
    logic [6:0] exp_tab [10];
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end
    // short loss count keeps the run brief
    lndid_core #(.LOSS_FRAMES(4)) u_lndid_core (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .ce(1'b1), .frm(frm), .frm_valid(frm_valid), .frame_tick(frame_tick),
        .motor_quiet(motor_quiet), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd(cmd), .link_lost(link_lost),
        .sleep_req(sleep_req), .ref_move_start(ref_move_start),
        .safe_move_start(safe_move_start), .irq(irq));
    lndid_master u_lndid_master (.clk_sys(clk_sys), .frm(frm), .frm_valid(frm_valid),
        .frame_tick(frame_tick));
    // pulses last one cycle, so they are counted as they pass
    always @(posedge clk_sys) begin
        if (cmd_valid === 1'b1) begin
            n_cmd <= n_cmd + 1;
            last_code <= cmd.code;
            last_ptr <= cmd.ptr;
        end
        if (safe_move_start === 1'b1) n_safe <= n_safe + 1;
        if (ref_move_start === 1'b1) n_ref <= n_ref + 1;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // apb transfer; request held until pready is seen
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // only the watchdog ends a wait that never sees pready
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait3();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask
    function automatic logic [9:0] pr(input logic [3:0] p, input logic [5:0] id);
        return {id, p};
    endfunction
    task automatic check_tab();
        for (int i = 0; i < 10; i++) begin
            apb(1'b0, lndid_pkg::A_TAB + 12'(4 * i), 32'h0);
            check(rd, {25'h0, exp_tab[i]});
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, lndid_pkg::A_SAFE, 32'h0);
        check(rd, 32'h400);
        apb(1'b0, 12'h020, 32'h0);
        check(err, 1'b1);
        apb(1'b1, lndid_pkg::A_CTRL, 32'h3);
        apb(1'b1, lndid_pkg::A_MASK, 32'h4);
        $display("registers test done");
    endtask
    task automatic t_assign();
        logic [39:0] a = {pr(4'h0, 6'h18), pr(4'h3, 6'h3c), pr(4'h5, 6'h09), pr(4'h2, 6'h20)};
        logic [39:0] b = {pr(4'h4, 6'h3f), pr(4'h8, 6'h1a), pr(4'h1, 6'h28), pr(4'h9, 6'h30)};
        foreach (exp_tab[i]) exp_tab[i] = 7'h0;
        u_lndid_master.assign4(8'h85, a, 1'b1);
        u_lndid_master.assign4(8'h00, a, 1'b0);
        wait3();
        check_tab();
        u_lndid_master.assign4(8'h00, a, 1'b1);
        u_lndid_master.assign4(8'h83, b, 1'b1);
        wait3();
        exp_tab[0] = 7'h58;
        exp_tab[2] = 7'h60;
        exp_tab[5] = 7'h49;
        exp_tab[1] = 7'h68;
        exp_tab[8] = 7'h5a;
        exp_tab[9] = 7'h70;
        check_tab();
        $display("assignment test done");
    endtask
    // send one frame and compare what, if anything, comes out
    task automatic frame_cmd(input logic [5:0] id, input logic [3:0] len,
            input logic [15:0] d, input int n, input logic [6:0] c, input logic [3:0] p);
        int base = n_cmd;
        u_lndid_master.send(id, len, 1'b1, {48'h0, d});
        wait3();
        check(n_cmd - base, n);
        if (n > 0) check({p, last_code}, {p, c});
        if (n > 0) check(last_ptr, p);
    endtask
    task automatic t_cmds();
        logic [6:0] codes [17] = '{7'h00, 7'h01, 7'h02, 7'h03, 7'h04, 7'h05, 7'h06, 7'h08,
            7'h09, 7'h0b, 7'h0c, 7'h0d, 7'h0e, 7'h0f, 7'h10, 7'h16, 7'h2f};
        foreach (codes[i]) frame_cmd(6'h18, 4'h2, {8'h00, 1'b0, codes[i]}, 1, codes[i], 4'h0);
        frame_cmd(6'h09, 4'h2, 16'h0, 1, lndid_pkg::C_CMP1, 4'h5);
        frame_cmd(6'h33, 4'h8, 16'h0, 1, lndid_pkg::C_MOVE_PAR, 4'h9);
        frame_cmd(6'h34, 4'h8, 16'h0, 0, 7'h0, 4'h0);
        frame_cmd(6'h3d, 4'h8, 16'h0, 0, 7'h0, 4'h0);
        u_lndid_master.send(6'h1a, 4'h2, 1'b1, {48'h0, 16'h8380});
        frame_cmd(6'h3d, 4'h8, 16'h0, 1, lndid_pkg::C_RD_LOC, 4'h8);
        u_lndid_master.send(6'h3c, 4'h8, 1'b1, {40'h0, 8'h83, 8'h82, 8'h80});
        frame_cmd(6'h3d, 4'h8, 16'h0, 1, lndid_pkg::C_RD_FUSE, 4'h8);
        frame_cmd(6'h28, 4'h4, 16'h8385, 1, lndid_pkg::C_HALT, 4'h1);
        frame_cmd(6'h28, 4'h4, 16'h8485, 0, 7'h0, 4'h0);
        frame_cmd(6'h18, 4'h8, 16'h0005, 0, 7'h0, 4'h0);
        $display("command test done");
    endtask
    task automatic t_loss();
        apb(1'b1, lndid_pkg::A_SAFE, 32'h123);
        apb(1'b1, lndid_pkg::A_CTRL, 32'h203);
        apb(1'b1, lndid_pkg::A_IRQ, 32'hf);
        wait3();
        check(irq, 1'b0);
        u_lndid_master.tick(3);
        wait3();
        check(link_lost, 1'b0);
        u_lndid_master.tick(1);
        wait3();
        check(link_lost, 1'b1);
        check(n_safe, 1);
        check(n_ref, 0);
        check(sleep_req, 1'b0);
        check(irq, 1'b1);
        @(posedge clk_sys);
        motor_quiet <= 1'b1;
        wait3();
        check(sleep_req, 1'b1);
        apb(1'b1, lndid_pkg::A_IRQ, 32'h4);
        wait3();
        check(irq, 1'b0);
        u_lndid_master.send(6'h18, 4'h2, 1'b1, 64'h0);
        wait3();
        check(link_lost, 1'b0);
        $display("link loss test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        motor_quiet = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        t_regs();
        t_assign();
        t_cmds();
        t_loss();
        stop_test();
    end
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        #500000;
        error_cnt++;
        stop_test();
    end
endmodule
`default_nettype wire
